// [logic/e1sas_top.sv]
`timescale 1ns/1ps
`default_nettype none
module e1sas_top (
   input  wire logic                   clk_in,
   input  wire logic                   nrst_in,
   input  wire logic                   rx_clock_in,
   input  wire logic                   rx_positive_rail_in,
   input  wire logic                   rx_negative_rail_in,
   input  wire e1sas_pkg::e1sas_sync_t sync_in,
   input  wire e1sas_pkg::e1sas_ts16_t ts16_in,
   input  wire e1sas_pkg::e1sas_nfas_t nfas_in,
   input  wire logic [7:0]             addr_in,
   input  wire logic [7:0]             wdata_in,
   input  wire logic                   wr_in,
   input  wire logic                   rd_in,
   output logic [7:0]                  rdata_out,
   output logic                        irq_out
);

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic logic [1:0] sat_zero_add(input logic [1:0] cnt, input logic is_zero);
      sat_zero_add = (is_zero && cnt < e1sas_pkg::ZERO_LIMIT) ? cnt + 2'h1 : cnt;
   endfunction : sat_zero_add

   function automatic logic [1:0] byte_zeros(input logic [1:0] cnt, input logic [7:0] b);
      logic [1:0] c;
      c = cnt;
      for (int i = 0; i < 8; i++) begin
         c = sat_zero_add(c, ~b[i]);
      end
      byte_zeros = c;
   endfunction : byte_zeros

   // ----------------------------------------------------------------------
   // pin synchronisers and bit strobe
   // ----------------------------------------------------------------------
   logic [1:0] clk_sync_r;
   logic [1:0] pos_sync_r;
   logic [1:0] neg_sync_r;
   logic       clk_last_r;
   logic       bit_en;
   logic       mark;

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         clk_sync_r <= 2'h0;
         pos_sync_r <= 2'h0;
         neg_sync_r <= 2'h0;
         clk_last_r <= 1'b0;
      end else begin
         clk_sync_r <= {clk_sync_r[0], rx_clock_in};
         pos_sync_r <= {pos_sync_r[0], rx_positive_rail_in};
         neg_sync_r <= {neg_sync_r[0], rx_negative_rail_in};
         clk_last_r <= clk_sync_r[1];
      end
   end

   assign bit_en = clk_sync_r[1] & ~clk_last_r;
   assign mark   = pos_sync_r[1] | neg_sync_r[1];

   // ----------------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------------
   logic [7:0] control_r;
   logic [7:0] int_mask_r;
   logic       wr_control;

   assign wr_control = wr_in && (addr_in == e1sas_pkg::ADDR_CONTROL);

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         control_r  <= e1sas_pkg::CONTROL_RESET;
         int_mask_r <= e1sas_pkg::INT_MASK_RESET;
      end else if (wr_in) begin
         if (addr_in == e1sas_pkg::ADDR_CONTROL) begin
            control_r <= wdata_in;
         end
         if (addr_in == e1sas_pkg::ADDR_INT_MASK) begin
            int_mask_r <= wdata_in;
         end
      end
   end

   // ----------------------------------------------------------------------
   // CRC4 search counter
   // ----------------------------------------------------------------------
   logic [5:0] crc4_search_count_r;

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         crc4_search_count_r <= 6'h00;
      end else if (!control_r[e1sas_pkg::CTL_CRC4_MODE_BIT]
                   || (wr_control && !wdata_in[e1sas_pkg::CTL_CRC4_MODE_BIT])) begin
         crc4_search_count_r <= 6'h00;
      end else if (sync_in.crc4_locked) begin
         crc4_search_count_r <= 6'h00;
      end else if (sync_in.crc4_timeout) begin
         crc4_search_count_r <= crc4_search_count_r + 6'h01;
      end
   end

   // ----------------------------------------------------------------------
   // signaling timeslot over one multiframe
   // ----------------------------------------------------------------------
   logic [7:0] prev_sig_r [e1sas_pkg::MF_FRAMES];
   logic [1:0] sig_zeros_r;
   logic       sig_any_one_r;
   logic       sig_change_r;
   logic       sig_ones_alarm_r;
   logic       sig_zeros_alarm_r;
   logic       dist_prev_r;
   logic       dist_alarm_r;
   logic [1:0] sig_zeros_nxt;
   logic       sig_change_nxt;
   logic       dist_bit;

   assign sig_zeros_nxt  = byte_zeros(sig_zeros_r, ts16_in.data);
   assign sig_change_nxt = sig_change_r || (prev_sig_r[ts16_in.frame] != ts16_in.data);
   assign dist_bit       = ts16_in.data[e1sas_pkg::DIST_MF_BIT];

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         for (int i = 0; i < e1sas_pkg::MF_FRAMES; i++) begin
            prev_sig_r[i] <= 8'h00;
         end
      end else if (ts16_in.valid) begin
         prev_sig_r[ts16_in.frame] <= ts16_in.data;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         sig_zeros_r   <= 2'h0;
         sig_any_one_r <= 1'b0;
         sig_change_r  <= 1'b0;
      end else if (ts16_in.valid) begin
         if (ts16_in.frame == e1sas_pkg::MF_LAST_FRAME) begin
            sig_zeros_r   <= 2'h0;
            sig_any_one_r <= 1'b0;
            sig_change_r  <= 1'b0;
         end else begin
            sig_zeros_r   <= sig_zeros_nxt;
            sig_any_one_r <= sig_any_one_r | (|ts16_in.data);
            sig_change_r  <= sig_change_nxt;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         sig_ones_alarm_r  <= 1'b0;
         sig_zeros_alarm_r <= 1'b0;
      end else if (ts16_in.valid && ts16_in.frame == e1sas_pkg::MF_LAST_FRAME) begin
         sig_ones_alarm_r  <= (sig_zeros_nxt < e1sas_pkg::ZERO_LIMIT) || sig_change_nxt;
         sig_zeros_alarm_r <= !(sig_any_one_r | (|ts16_in.data)) || sig_change_nxt;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         dist_prev_r  <= 1'b0;
         dist_alarm_r <= 1'b0;
      end else if (ts16_in.valid && ts16_in.frame == 4'h0) begin
         dist_prev_r <= dist_bit;
         if (dist_bit == dist_prev_r) begin
            dist_alarm_r <= dist_bit;
         end
      end
   end

   // ----------------------------------------------------------------------
   // unframed all ones over 512 bits
   // ----------------------------------------------------------------------
   logic [8:0] ua_pos_r;
   logic [1:0] ua_zeros_r;
   logic       ua_alarm_r;
   logic [1:0] ua_zeros_nxt;

   assign ua_zeros_nxt = sat_zero_add(ua_zeros_r, ~mark);

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         ua_pos_r   <= 9'h000;
         ua_zeros_r <= 2'h0;
         ua_alarm_r <= 1'b0;
      end else if (bit_en) begin
         ua_pos_r <= ua_pos_r + 9'h001;
         if (ua_pos_r == e1sas_pkg::UA_WINDOW_LAST) begin
            ua_zeros_r <= 2'h0;
            ua_alarm_r <= ua_zeros_nxt < e1sas_pkg::ZERO_LIMIT;
         end else begin
            ua_zeros_r <= ua_zeros_nxt;
         end
      end
   end

   // ----------------------------------------------------------------------
   // remote alarm from non-align frames
   // ----------------------------------------------------------------------
   logic [1:0] remote_run_r;
   logic       remote_last_r;
   logic       remote_alarm_r;
   logic       remote_bit;
   logic [1:0] remote_run_nxt;

   assign remote_bit     = nfas_in.data[e1sas_pkg::REMOTE_BIT];
   assign remote_run_nxt = (remote_bit != remote_last_r) ? 2'h1 :
                           (remote_run_r < e1sas_pkg::REMOTE_RUN) ? remote_run_r + 2'h1 : remote_run_r;

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         remote_run_r   <= 2'h0;
         remote_last_r  <= 1'b0;
         remote_alarm_r <= 1'b0;
      end else if (nfas_in.valid) begin
         remote_last_r <= remote_bit;
         remote_run_r  <= remote_run_nxt;
         if (remote_run_nxt == e1sas_pkg::REMOTE_RUN) begin
            remote_alarm_r <= remote_bit;
         end
      end
   end

   // ----------------------------------------------------------------------
   // carrier loss
   // ----------------------------------------------------------------------
   logic carrier_loss;

   e1sas_carrier_loss u_carrier_loss (
      .clk_in      (clk_in),
      .nrst_in     (nrst_in),
      .bit_en_in   (bit_en),
      .mark_in     (mark),
      .extended_in (control_r[e1sas_pkg::CTL_EXT_CL_BIT]),
      .loss_out    (carrier_loss)
   );

   // ----------------------------------------------------------------------
   // status registers
   // ----------------------------------------------------------------------
   logic [7:0] alarm_status;
   logic [7:0] sync_status;

   always_comb begin
      alarm_status                             = 8'h00;
      alarm_status[e1sas_pkg::ALM_SIG_ONES]    = sig_ones_alarm_r;
      alarm_status[e1sas_pkg::ALM_DIST_MF]     = dist_alarm_r;
      alarm_status[e1sas_pkg::ALM_SIG_ZEROS]   = sig_zeros_alarm_r;
      alarm_status[e1sas_pkg::ALM_SLIP]        = 1'b0;
      alarm_status[e1sas_pkg::ALM_UNFR_ONES]   = ua_alarm_r;
      alarm_status[e1sas_pkg::ALM_REMOTE]      = remote_alarm_r;
      alarm_status[e1sas_pkg::ALM_CARRIER]     = carrier_loss;
      alarm_status[e1sas_pkg::ALM_SYNC_LOSS]   = !sync_in.in_sync;
   end

   assign sync_status = {crc4_search_count_r[5:2], crc4_search_count_r[0],
                         sync_in.fas_hunt,
                         sync_in.cas_hunt,
                         sync_in.crc4_hunt};

   // ----------------------------------------------------------------------
   // interrupt: sticky on alarm rising edge, cleared by reading
   // ----------------------------------------------------------------------
   logic [7:0] alarm_last_r;
   logic [7:0] int_status_r;
   logic [7:0] alarm_rise;
   logic       rd_int;

   assign alarm_rise = alarm_status & ~alarm_last_r;
   assign rd_int     = rd_in && (addr_in == e1sas_pkg::ADDR_INT_STATUS);

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         alarm_last_r <= 8'h00;
         int_status_r <= 8'h00;
      end else begin
         alarm_last_r <= alarm_status;
         int_status_r <= (rd_int ? 8'h00 : int_status_r) | alarm_rise;
      end
   end

   assign irq_out = |(int_status_r & int_mask_r);

   // ----------------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         rdata_out <= 8'h00;
      end else if (rd_in) begin
         unique case (addr_in)
            e1sas_pkg::ADDR_ALARM_STATUS: rdata_out <= alarm_status;
            e1sas_pkg::ADDR_SYNC_STATUS:  rdata_out <= sync_status;
            e1sas_pkg::ADDR_CONTROL:      rdata_out <= control_r;
            e1sas_pkg::ADDR_INT_STATUS:   rdata_out <= int_status_r;
            e1sas_pkg::ADDR_INT_MASK:     rdata_out <= int_mask_r;
            default:                      rdata_out <= 8'h00;
         endcase
      end else begin
         rdata_out <= 8'h00;
      end
   end

endmodule : e1sas_top
`default_nettype wire

// [logic/e1sas_pkg.sv]
package e1sas_pkg;

   // ----------------------------------------------------------------------
   // register map (8-bit data, byte addresses)
   // ----------------------------------------------------------------------
   localparam logic [7:0] ADDR_ALARM_STATUS = 8'h06;
   localparam logic [7:0] ADDR_SYNC_STATUS  = 8'h1e;
   localparam logic [7:0] ADDR_CONTROL      = 8'h10;
   localparam logic [7:0] ADDR_INT_STATUS   = 8'h11;
   localparam logic [7:0] ADDR_INT_MASK     = 8'h12;

   // control register fields
   localparam int CTL_CRC4_MODE_BIT = 0;
   localparam int CTL_EXT_CL_BIT    = 1;
   localparam logic [7:0] CONTROL_RESET  = 8'h00;
   localparam logic [7:0] INT_MASK_RESET = 8'h00;

   // alarm status field positions
   localparam int ALM_SIG_ONES   = 7;
   localparam int ALM_DIST_MF    = 6;
   localparam int ALM_SIG_ZEROS  = 5;
   localparam int ALM_SLIP       = 4;
   localparam int ALM_UNFR_ONES  = 3;
   localparam int ALM_REMOTE     = 2;
   localparam int ALM_CARRIER    = 1;
   localparam int ALM_SYNC_LOSS  = 0;

   // ----------------------------------------------------------------------
   // line criteria
   // ----------------------------------------------------------------------
   localparam int          MF_FRAMES         = 16;
   localparam logic [3:0]  MF_LAST_FRAME     = 4'hf;
   localparam logic [1:0]  ZERO_LIMIT        = 2'h3;
   localparam logic [8:0]  UA_WINDOW_LAST    = 9'h1ff;
   localparam logic [1:0]  REMOTE_RUN        = 2'h3;
   localparam logic [11:0] CL_ZEROS_NORMAL   = 12'h0ff;
   localparam logic [11:0] CL_ZEROS_EXTENDED = 12'h800;
   localparam logic [7:0]  CL_WINDOW_LAST    = 8'hfe;
   localparam logic [5:0]  CL_ONES_CLEAR     = 6'h20;
   localparam int          DIST_MF_BIT       = 2;
   localparam int          REMOTE_BIT        = 5;

   // search period and host guidance, in ms
   localparam int CRC4_SEARCH_MS  = 8;
   localparam int CRC4_ABANDON_MS = 400;

   // ----------------------------------------------------------------------
   // carriers from the framer (same clock)
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic fas_hunt;
      logic cas_hunt;
      logic crc4_hunt;
      logic crc4_timeout;
      logic crc4_locked;
      logic in_sync;
   } e1sas_sync_t;

   typedef struct packed {
      logic       valid;
      logic [3:0] frame;
      logic [7:0] data;
   } e1sas_ts16_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } e1sas_nfas_t;

endpackage : e1sas_pkg

// [logic/e1sas_carrier_loss.sv]
`timescale 1ns/1ps
`default_nettype none
module e1sas_carrier_loss (
   input  wire logic clk_in,
   input  wire logic nrst_in,
   input  wire logic bit_en_in,
   input  wire logic mark_in,
   input  wire logic extended_in,
   output logic      loss_out
);

   logic [11:0] zero_run_r;
   logic [7:0]  win_pos_r;
   logic [5:0]  ones_r;
   logic [11:0] limit;

   assign limit = extended_in ? e1sas_pkg::CL_ZEROS_EXTENDED : e1sas_pkg::CL_ZEROS_NORMAL;

   // ----------------------------------------------------------------------
   // consecutive zero run
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         zero_run_r <= 12'h000;
      end else if (bit_en_in) begin
         if (mark_in) begin
            zero_run_r <= 12'h000;
         end else if (zero_run_r < limit) begin
            zero_run_r <= zero_run_r + 12'h001;
         end
      end
   end

   // ----------------------------------------------------------------------
   // ones density window
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         win_pos_r <= 8'h00;
         ones_r    <= 6'h00;
      end else if (bit_en_in) begin
         if (win_pos_r == e1sas_pkg::CL_WINDOW_LAST) begin
            win_pos_r <= 8'h00;
         end else begin
            win_pos_r <= win_pos_r + 8'h01;
         end
         // count restarts on the first bit of a window, so the last bit of a window still counts
         if (win_pos_r == 8'h00) begin
            ones_r <= {5'h00, mark_in};
         end else if (mark_in && ones_r < e1sas_pkg::CL_ONES_CLEAR) begin
            ones_r <= ones_r + 6'h01;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         loss_out <= 1'b0;
      end else if (zero_run_r >= limit) begin
         loss_out <= 1'b1;
      end else if (ones_r >= e1sas_pkg::CL_ONES_CLEAR) begin
         loss_out <= 1'b0;
      end
   end

endmodule : e1sas_carrier_loss
`default_nettype wire

// [tb/e1sas_top_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module e1sas_top_sva (
   input wire logic                   clk_in,
   input wire logic                   nrst_in,
   input wire e1sas_pkg::e1sas_sync_t sync_in,
   input wire logic [7:0]             addr_in,
   input wire logic [7:0]             wdata_in,
   input wire logic                   wr_in,
   input wire logic                   rd_in,
   input wire logic [7:0]             rdata_out,
   input wire logic                   irq_out
);
   // ----------------------------------------------------------------
   // reference search count and mask
   // ----------------------------------------------------------------
   logic [5:0] cnt_r;
   logic       mode_r;
   logic [7:0] mask_r;
   logic       busy_r;
   logic       ev;
   assign ev = sync_in.crc4_timeout | sync_in.crc4_locked | (wr_in && addr_in == e1sas_pkg::ADDR_CONTROL);
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         cnt_r  <= 6'h00;
         mode_r <= 1'b0;
         mask_r <= 8'h00;
         busy_r <= 1'b0;
      end else begin
         busy_r <= ev;
         if (wr_in && addr_in == e1sas_pkg::ADDR_CONTROL) mode_r <= wdata_in[e1sas_pkg::CTL_CRC4_MODE_BIT];
         if (wr_in && addr_in == e1sas_pkg::ADDR_INT_MASK) mask_r <= wdata_in;
         if (!mode_r) cnt_r <= 6'h00;
         else if (sync_in.crc4_locked) cnt_r <= 6'h00;
         else if (sync_in.crc4_timeout) cnt_r <= cnt_r + 6'h01;
      end
   end
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   a_search_count: assert property (
      rd_in && addr_in == e1sas_pkg::ADDR_SYNC_STATUS && !ev && !busy_r
      |=> rdata_out[7:3] == {cnt_r[5:2], cnt_r[0]}) else $error("search count readback wrong");
   a_fas_flag: assert property (
      rd_in && addr_in == e1sas_pkg::ADDR_SYNC_STATUS && $stable(sync_in.fas_hunt)
      |=> rdata_out[2] == $past(sync_in.fas_hunt)) else $error("frame search flag wrong");
   a_cas_flag: assert property (
      rd_in && addr_in == e1sas_pkg::ADDR_SYNC_STATUS && $stable(sync_in.cas_hunt)
      |=> rdata_out[1] == $past(sync_in.cas_hunt)) else $error("cas search flag wrong");
   a_crc_flag: assert property (
      rd_in && addr_in == e1sas_pkg::ADDR_SYNC_STATUS && $stable(sync_in.crc4_hunt)
      |=> rdata_out[0] == $past(sync_in.crc4_hunt)) else $error("crc4 search flag wrong");
   a_sync_loss: assert property (
      rd_in && addr_in == e1sas_pkg::ADDR_ALARM_STATUS && $stable(sync_in.in_sync)
      |=> rdata_out[0] == !$past(sync_in.in_sync)) else $error("sync loss bit wrong");
   a_rdata_idle: assert property (
      !rd_in |=> rdata_out == 8'h00) else $error("read data outside read slot");
   a_unmapped_read: assert property (
      rd_in && addr_in == 8'h20 |=> rdata_out == 8'h00) else $error("unmapped read not zero");
   a_irq_masked: assert property (
      mask_r == 8'h00 && $past(mask_r) == 8'h00 |-> !irq_out) else $error("irq with mask clear");
endmodule : e1sas_top_sva
bind e1sas_top e1sas_top_sva u_sva (.clk_in(clk_in), .nrst_in(nrst_in), .sync_in(sync_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .irq_out(irq_out));
`default_nettype wire

// [tb/e1sas_line_rx.sv]
`timescale 1ns/1ps
`default_nettype none
module e1sas_line_rx (
   output logic rx_clock_out,
   output logic pos_out,
   output logic neg_out
);
   logic polarity_r;
   initial begin
      rx_clock_out = 1'b0;
      pos_out      = 1'b0;
      neg_out      = 1'b0;
      polarity_r   = 1'b0;
   end
   // alternate-mark bits at 4 MHz; clock stands still between bursts
   task automatic send(input int n, input logic mark);
      for (int i = 0; i < n; i++) begin
         pos_out = mark & ~polarity_r;
         neg_out = mark & polarity_r;
         if (mark) polarity_r = ~polarity_r;
         #125 rx_clock_out = 1'b1;
         #125 rx_clock_out = 1'b0;
      end
      // released rails never hold the last bit
      pos_out = ~pos_out;
      neg_out = ~neg_out;
   endtask : send
endmodule : e1sas_line_rx
`default_nettype wire

// [tb/e1sas_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module e1sas_top_bench;
   logic                   clk_in  = 1'b0;
   logic                   nrst_in = 1'b0;
   e1sas_pkg::e1sas_sync_t sync    = 6'h01;
   e1sas_pkg::e1sas_ts16_t ts16    = 13'h0000;
   e1sas_pkg::e1sas_nfas_t nfas    = 9'h000;
   logic [7:0]             addr    = 8'h00;
   logic [7:0]             wdata   = 8'h00;
   logic                   wr_s    = 1'b0;
   logic                   rd_s    = 1'b0;
   logic [7:0]             rdata;
   logic                   irq;
   wire                    rx_clk;
   wire                    pos;
   wire                    neg;
   int                     errors   = 0;
   int                     n_checks = 0;
   int                     kinds[6] = '{0, 0, 1, 1, 2, 2};
   logic [7:0]             exps[6]  = '{8'ha0, 8'hc0, 8'he0, 8'h40, 8'he0, 8'h20};
   always #20 clk_in = ~clk_in;
   e1sas_line_rx line_rx (.rx_clock_out(rx_clk), .pos_out(pos), .neg_out(neg));
   e1sas_top uut (.clk_in(clk_in), .nrst_in(nrst_in), .rx_clock_in(rx_clk),
      .rx_positive_rail_in(pos), .rx_negative_rail_in(neg), .sync_in(sync), .ts16_in(ts16),
      .nfas_in(nfas), .addr_in(addr), .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s),
      .rdata_out(rdata), .irq_out(irq));
   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr  <= a;
      wdata <= d;
      wr_s  <= 1'b1;
      @(posedge clk_in);
      wr_s  <= 1'b0;
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_in);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk_in);
      rd_s <= 1'b0;
      #1 check(rdata, e);
   endtask : rdc
   task automatic pulse(input int n, input bit lock);
      repeat (n) begin
         @(posedge clk_in);
         if (lock) sync.crc4_locked <= 1'b1;
         else sync.crc4_timeout <= 1'b1;
         @(posedge clk_in);
         sync.crc4_locked  <= 1'b0;
         sync.crc4_timeout <= 1'b0;
      end
   endtask : pulse
   task automatic mf(input int kind);
      for (int f = 0; f < 16; f++) begin
         @(posedge clk_in);
         ts16 <= {1'b1, 4'(f), (kind == 2) ? 8'h00 : (kind == 1 && f == 1) ? 8'hf8 : 8'hff};
         @(posedge clk_in);
         ts16.valid <= 1'b0;
      end
   endtask : mf
   task automatic occ(input int n, input bit b);
      repeat (n) begin
         @(posedge clk_in);
         nfas <= {1'b1, b ? 8'h20 : 8'h00};
         @(posedge clk_in);
         nfas.valid <= 1'b0;
      end
   endtask : occ
   task automatic line(input int n, input logic m);
      line_rx.send(n, m);
      repeat (8) @(posedge clk_in);
   endtask : line
   task automatic complete_run;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (60000) @(posedge clk_in);
      errors++;
      complete_run();
   end
   initial begin
      repeat (2) @(posedge clk_in);
      nrst_in <= 1'b1;
      rdc(e1sas_pkg::ADDR_ALARM_STATUS, 8'h00);
      @(posedge clk_in);
      sync.in_sync <= 1'b0;
      rdc(e1sas_pkg::ADDR_ALARM_STATUS, 8'h01);
      @(posedge clk_in);
      sync.in_sync <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_in);
         {sync.fas_hunt, sync.cas_hunt, sync.crc4_hunt} <= 3'h4 >> i;
         rdc(e1sas_pkg::ADDR_SYNC_STATUS, 8'h04 >> i);
      end
      @(posedge clk_in);
      {sync.fas_hunt, sync.cas_hunt, sync.crc4_hunt} <= 3'h0;
      wr(e1sas_pkg::ADDR_ALARM_STATUS, 8'hff);
      rdc(e1sas_pkg::ADDR_ALARM_STATUS, 8'h00);
      rdc(8'h20, 8'h00);
      wr(e1sas_pkg::ADDR_CONTROL, 8'h01);
      pulse(3, 0);
      rdc(e1sas_pkg::ADDR_SYNC_STATUS, 8'h08);
      pulse(e1sas_pkg::CRC4_ABANDON_MS / e1sas_pkg::CRC4_SEARCH_MS - 3, 0);
      rdc(e1sas_pkg::ADDR_SYNC_STATUS, 8'hc0);
      pulse(19, 0);
      rdc(e1sas_pkg::ADDR_SYNC_STATUS, 8'h18);
      pulse(1, 1);
      rdc(e1sas_pkg::ADDR_SYNC_STATUS, 8'h00);
      pulse(4, 0);
      rdc(e1sas_pkg::ADDR_SYNC_STATUS, 8'h10);
      wr(e1sas_pkg::ADDR_CONTROL, 8'h00);
      rdc(e1sas_pkg::ADDR_SYNC_STATUS, 8'h00);
      pulse(2, 0);
      rdc(e1sas_pkg::ADDR_SYNC_STATUS, 8'h00);
      for (int k = 0; k < 6; k++) begin
         mf(kinds[k]);
         rdc(e1sas_pkg::ADDR_ALARM_STATUS, exps[k]);
      end
      occ(2, 1);
      rdc(e1sas_pkg::ADDR_ALARM_STATUS, 8'h20);
      occ(1, 1);
      rdc(e1sas_pkg::ADDR_ALARM_STATUS, 8'h24);
      occ(2, 0);
      rdc(e1sas_pkg::ADDR_ALARM_STATUS, 8'h24);
      occ(1, 0);
      rdc(e1sas_pkg::ADDR_ALARM_STATUS, 8'h20);
      rdc(e1sas_pkg::ADDR_INT_STATUS, 8'he5);
      rdc(e1sas_pkg::ADDR_INT_STATUS, 8'h00);
      wr(e1sas_pkg::ADDR_INT_MASK, 8'h02);
      #1 check({7'h00, irq}, 8'h00);
      line(254, 0);
      rdc(e1sas_pkg::ADDR_ALARM_STATUS, 8'h20);
      line(1, 0);
      rdc(e1sas_pkg::ADDR_ALARM_STATUS, 8'h22);
      check({7'h00, irq}, 8'h01);
      rdc(e1sas_pkg::ADDR_INT_STATUS, 8'h02);
      check({7'h00, irq}, 8'h00);
      line(1024, 1);
      rdc(e1sas_pkg::ADDR_ALARM_STATUS, 8'h28);
      line(2, 0);
      line(255, 1);
      rdc(e1sas_pkg::ADDR_ALARM_STATUS, 8'h28);
      line(3, 0);
      line(509, 1);
      rdc(e1sas_pkg::ADDR_ALARM_STATUS, 8'h20);
      wr(e1sas_pkg::ADDR_CONTROL, 8'h02);
      line(2047, 0);
      rdc(e1sas_pkg::ADDR_ALARM_STATUS, 8'h20);
      line(1, 0);
      rdc(e1sas_pkg::ADDR_ALARM_STATUS, 8'h22);
      complete_run();
   end
endmodule : e1sas_top_bench
`default_nettype wire
